// file: rbpe_event_select.sv
`timescale 1ns/100ps
`include "rbpe_params.svh"
module rbpe_event_select #(
  parameter int CNT_IDX = 0
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire rbpe_pkg::rbpe_code_t eventCode,
  input wire rbpe_pkg::rbpe_mask_t eventMask,
  input wire rbpe_pkg::rbpe_dir_t reqRingUse,
  input wire rbpe_pkg::rbpe_dir_t ackRingUse,
  input wire rbpe_pkg::rbpe_dir_t dataRingUse,
  input wire rbpe_pkg::rbpe_dir_t snoopRingUse,
  input wire rbpe_pkg::rbpe_queue_t ingressNonEmpty,
  input wire logic ackIngressBounce,
  input wire rbpe_pkg::rbpe_queue_t egressFull,
  input wire rbpe_pkg::rbpe_queue_t egressNonEmpty,
  input wire rbpe_pkg::rbpe_queue_t egressAlloc,
  output logic incr
);
  import rbpe_pkg::*;

  localparam bit ONLY0 = (CNT_IDX == 0);
  localparam bit LOW2 = (CNT_IDX <= 1);

  // Any selected subevent gives one count, never more
  function automatic logic anyHit(input logic [3:0] sel, input logic [3:0] act);
    anyHit = |(sel & act);
  endfunction

  logic incr_nxt;

  always_comb begin
    incr_nxt = 1'b0;
    case (eventCode)
      `RBPE_EV_CYCLE_TICK: incr_nxt = 1'b1;
      `RBPE_EV_REQ_RING: incr_nxt = anyHit(eventMask[3:0], reqRingUse);
      `RBPE_EV_ACK_RING: incr_nxt = anyHit(eventMask[3:0], ackRingUse);
      `RBPE_EV_DATA_RING: incr_nxt = anyHit(eventMask[3:0], dataRingUse);
      `RBPE_EV_SNOOP_RING: incr_nxt = anyHit(eventMask[3:0], snoopRingUse);
      `RBPE_EV_IN_NONEMPTY: begin
        incr_nxt = LOW2 && anyHit({1'b0, eventMask[5:3]}, {1'b0, ingressNonEmpty});
      end
      `RBPE_EV_ACK_BOUNCE: incr_nxt = ONLY0 && ackIngressBounce;
      // No direction term: egress events see whole queues only
      `RBPE_EV_EG_FULL: begin
        incr_nxt = ONLY0 && anyHit({1'b0, eventMask[2:0]}, {1'b0, egressFull});
      end
      `RBPE_EV_EG_NONEMPTY: begin
        incr_nxt = ONLY0 && anyHit({1'b0, eventMask[2:0]}, {1'b0, egressNonEmpty});
      end
      `RBPE_EV_EG_ALLOC: begin
        incr_nxt = ONLY0 && anyHit({1'b0, eventMask[2:0]}, {1'b0, egressAlloc});
      end
      default: incr_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      incr <= 1'b0;
    end else begin
      incr <= incr_nxt;
    end
  end

  tick_follows_a: assert property (@(posedge mclk) disable iff (!nrst)
    (eventCode == `RBPE_EV_CYCLE_TICK) |=> incr)
    else $error("cycle tick did not count");
  restricted_code_a: assert property (@(posedge mclk) disable iff (!nrst)
    (!ONLY0 && eventCode >= `RBPE_EV_EG_NONEMPTY && eventCode <= `RBPE_EV_EG_FULL) |=> !incr)
    else $error("egress event counted on wrong counter");
  unknown_code_a: assert property (@(posedge mclk) disable iff (!nrst)
    (eventCode == 8'h00) |=> !incr)
    else $error("unknown code counted");
  data_ring_a: assert property (@(posedge mclk) disable iff (!nrst)
    (eventCode == `RBPE_EV_DATA_RING) |=> (incr == $past(|(eventMask[3:0] & dataRingUse))))
    else $error("data ring use miscounted");
  ack_ring_a: assert property (@(posedge mclk) disable iff (!nrst)
    (eventCode == `RBPE_EV_ACK_RING && ackRingUse == 4'h0) |=> !incr)
    else $error("idle ack ring counted");
  req_ring_a: assert property (@(posedge mclk) disable iff (!nrst)
    (eventCode == `RBPE_EV_REQ_RING && (eventMask[0] && reqRingUse[0])) |=> incr)
    else $error("request ring use missed");
  ingress_sel_a: assert property (@(posedge mclk) disable iff (!nrst)
    (LOW2 && eventCode == `RBPE_EV_IN_NONEMPTY && eventMask[5] && ingressNonEmpty[2]) |=> incr)
    else $error("ingress nonempty missed");
  egress_full_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ONLY0 && eventCode == `RBPE_EV_EG_FULL && eventMask[2:0] == 3'h2 && !egressFull[1]) |=> !incr)
    else $error("egress full wrong queue");
  bounce_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ONLY0 && eventCode == `RBPE_EV_ACK_BOUNCE) |=> (incr == $past(ackIngressBounce)))
    else $error("bounce miscounted");
endmodule

// file: rbpe_params.svh
`ifndef RBPE_PARAMS_SVH
`define RBPE_PARAMS_SVH
`define RBPE_EV_CYCLE_TICK 8'h01
`define RBPE_EV_REQ_RING 8'h07
`define RBPE_EV_ACK_RING 8'h08
`define RBPE_EV_DATA_RING 8'h09
`define RBPE_EV_SNOOP_RING 8'h0A
`define RBPE_EV_IN_NONEMPTY 8'h10
`define RBPE_EV_ACK_BOUNCE 8'h12
`define RBPE_EV_EG_NONEMPTY 8'h23
`define RBPE_EV_EG_ALLOC 8'h24
`define RBPE_EV_EG_FULL 8'h25
`define RBPE_CODE_LSB 0
`define RBPE_MASK_LSB 8
`define RBPE_CNT_W 44
`define RBPE_NUM_CNT 4
`define RBPE_SNOOP_ANY_MASK 8'h0F
`endif

// file: rbpe_pkg.sv
package rbpe_pkg;
  typedef logic [7:0] rbpe_code_t;
  typedef logic [7:0] rbpe_mask_t;
  typedef logic [3:0] rbpe_dir_t;
  typedef logic [2:0] rbpe_queue_t;
  typedef logic [43:0] rbpe_count_t;
endpackage

// file: rbpe_perf_events.sv
`timescale 1ns/100ps
`include "rbpe_params.svh"
module rbpe_perf_events (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [15:0] ctlWord0,
  input wire logic [15:0] ctlWord1,
  input wire logic [15:0] ctlWord2,
  input wire logic [15:0] ctlWord3,
  input wire logic [3:0] counterEnable,
  input wire logic [3:0] counterClear,
  input wire rbpe_pkg::rbpe_dir_t reqRingUse,
  input wire rbpe_pkg::rbpe_dir_t ackRingUse,
  input wire rbpe_pkg::rbpe_dir_t dataRingUse,
  input wire rbpe_pkg::rbpe_dir_t snoopRingUse,
  input wire rbpe_pkg::rbpe_queue_t ingressNonEmpty,
  input wire logic ackIngressBounce,
  input wire rbpe_pkg::rbpe_queue_t egressFull,
  input wire rbpe_pkg::rbpe_queue_t egressNonEmpty,
  input wire rbpe_pkg::rbpe_queue_t egressAlloc,
  output logic [3:0] incrOut_r,
  output rbpe_pkg::rbpe_count_t count0_r,
  output rbpe_pkg::rbpe_count_t count1_r,
  output rbpe_pkg::rbpe_count_t count2_r,
  output rbpe_pkg::rbpe_count_t count3_r
);
  import rbpe_pkg::*;

  logic [15:0] ctlWords [`RBPE_NUM_CNT];
  logic [3:0] incr;
  rbpe_count_t count_r [`RBPE_NUM_CNT];

  assign ctlWords[0] = ctlWord0;
  assign ctlWords[1] = ctlWord1;
  assign ctlWords[2] = ctlWord2;
  assign ctlWords[3] = ctlWord3;

  for (genvar i = 0; i < `RBPE_NUM_CNT; i++) begin : g_sel
    rbpe_event_select #(
      .CNT_IDX(i)
    ) u_sel (
      .mclk(mclk),
      .nrst(nrst),
      .eventCode(ctlWords[i][`RBPE_CODE_LSB +: 8]),
      .eventMask(ctlWords[i][`RBPE_MASK_LSB +: 8]),
      .reqRingUse(reqRingUse),
      .ackRingUse(ackRingUse),
      .dataRingUse(dataRingUse),
      .snoopRingUse(snoopRingUse),
      .ingressNonEmpty(ingressNonEmpty),
      .ackIngressBounce(ackIngressBounce),
      .egressFull(egressFull),
      .egressNonEmpty(egressNonEmpty),
      .egressAlloc(egressAlloc),
      .incr(incr[i])
    );

    // Clear wins over counting; plain add wraps past bit 43
    always_ff @(posedge mclk) begin
      if (!nrst) begin
        count_r[i] <= 44'h000_0000_0000;
      end else if (counterClear[i]) begin
        count_r[i] <= 44'h000_0000_0000;
      end else if (counterEnable[i] && incr[i]) begin
        count_r[i] <= count_r[i] + 44'h000_0000_0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      incrOut_r <= 4'h0;
    end else begin
      incrOut_r <= incr & counterEnable;
    end
  end

  assign count0_r = count_r[0];
  assign count1_r = count_r[1];
  assign count2_r = count_r[2];
  assign count3_r = count_r[3];

  wrap_around_a: assert property (@(posedge mclk) disable iff (!nrst)
    (count_r[0] == 44'hFFF_FFFF_FFFF && counterEnable[0] && incr[0] && !counterClear[0])
    |=> (count_r[0] == 44'h000_0000_0000))
    else $error("counter did not wrap");
  count_step_a: assert property (@(posedge mclk) disable iff (!nrst)
    (!counterClear[1]) |=> (count_r[1] - $past(count_r[1]) <= 44'h000_0000_0001))
    else $error("counter stepped by more than one");
endmodule

// file: rbpe_ring_model.sv
`timescale 1ns/100ps
module rbpe_ring_model (
  input wire logic mclk,
  output rbpe_pkg::rbpe_dir_t reqRingUse,
  output rbpe_pkg::rbpe_dir_t ackRingUse,
  output rbpe_pkg::rbpe_dir_t dataRingUse,
  output rbpe_pkg::rbpe_dir_t snoopRingUse,
  output rbpe_pkg::rbpe_queue_t ingressNonEmpty,
  output logic ackIngressBounce,
  output rbpe_pkg::rbpe_queue_t egressFull,
  output rbpe_pkg::rbpe_queue_t egressNonEmpty,
  output rbpe_pkg::rbpe_queue_t egressAlloc
);
  import rbpe_pkg::*;
  // Single driver; inputs stay unknown only while reset holds the design
  // Use flags cover passing and sunk packets; own sends never show
  always @(posedge mclk) begin
    #1;
    reqRingUse = 4'($urandom);
    ackRingUse = 4'($urandom);
    dataRingUse = 4'($urandom);
    // Unidirectional, fixed to clockwise here by system setup
    snoopRingUse = 4'($urandom_range(3));
    ingressNonEmpty = 3'($urandom);
    ackIngressBounce = 1'($urandom);
    egressFull = 3'($urandom);
    egressNonEmpty = 3'($urandom);
    egressAlloc = 3'($urandom);
  end
endmodule

// file: rbpe_perf_events_bench.sv
`timescale 1ns/100ps
module rbpe_perf_events_bench;
  import rbpe_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] ctl [4] = '{default: 16'h0000};
  logic [3:0] counterEnable = 4'h0;
  logic [3:0] counterClear = 4'h0;
  rbpe_dir_t reqRingUse, ackRingUse, dataRingUse, snoopRingUse;
  rbpe_queue_t ingressNonEmpty, egressFull, egressNonEmpty, egressAlloc;
  logic ackIngressBounce;
  logic [3:0] incrOut_r;
  rbpe_count_t cnt [4];
  logic [3:0] expInc, expOut;
  rbpe_count_t expCnt [4];
  int num_errors = 0;
  int checks = 0;
  logic [7:0] codes [12] = '{8'h01, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h10, 8'h12, 8'h23,
                             8'h24, 8'h25, 8'h00, 8'h5A};
  always #2.5 mclk = ~mclk;
  rbpe_perf_events i_dut (.mclk(mclk), .nrst(nrst), .ctlWord0(ctl[0]), .ctlWord1(ctl[1]),
    .ctlWord2(ctl[2]), .ctlWord3(ctl[3]), .counterEnable(counterEnable),
    .counterClear(counterClear), .reqRingUse(reqRingUse), .ackRingUse(ackRingUse),
    .dataRingUse(dataRingUse), .snoopRingUse(snoopRingUse), .ingressNonEmpty(ingressNonEmpty),
    .ackIngressBounce(ackIngressBounce), .egressFull(egressFull), .egressNonEmpty(egressNonEmpty),
    .egressAlloc(egressAlloc), .incrOut_r(incrOut_r), .count0_r(cnt[0]), .count1_r(cnt[1]),
    .count2_r(cnt[2]), .count3_r(cnt[3]));
  rbpe_ring_model i_ring (.mclk(mclk), .reqRingUse(reqRingUse), .ackRingUse(ackRingUse),
    .dataRingUse(dataRingUse), .snoopRingUse(snoopRingUse), .ingressNonEmpty(ingressNonEmpty),
    .ackIngressBounce(ackIngressBounce), .egressFull(egressFull), .egressNonEmpty(egressNonEmpty),
    .egressAlloc(egressAlloc));
  function automatic logic evt(int idx, logic [15:0] w);
    logic [7:0] m;
    m = w[15:8];
    case (w[7:0])
      8'h01: return 1'b1;
      8'h07: return |(m[3:0] & reqRingUse);
      8'h08: return |(m[3:0] & ackRingUse);
      8'h09: return |(m[3:0] & dataRingUse);
      8'h0A: return |(m[3:0] & snoopRingUse);
      8'h10: return idx < 2 && |(m[5:3] & ingressNonEmpty);
      8'h12: return idx == 0 && ackIngressBounce;
      8'h23: return idx == 0 && |(m[2:0] & egressNonEmpty);
      8'h24: return idx == 0 && |(m[2:0] & egressAlloc);
      8'h25: return idx == 0 && |(m[2:0] & egressFull);
      default: return 1'b0;
    endcase
  endfunction
  always @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      expInc[i] <= nrst && evt(i, ctl[i]);
      expOut[i] <= nrst && expInc[i] && counterEnable[i];
      if (!nrst || counterClear[i]) expCnt[i] <= 44'h0;
      else if (counterEnable[i] && expInc[i]) expCnt[i] <= expCnt[i] + 44'h1;
    end
  end
  task automatic check(input logic [43:0] seen, input logic [43:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  always @(negedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      check(44'(incrOut_r[i]), 44'(expOut[i]));
      check(cnt[i], expCnt[i]);
    end
  end
  task automatic end_sim();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #500000;
    num_errors++;
    end_sim();
  end
  initial begin
    logic [7:0] c8;
    void'($urandom(32'hc2da_862d));
    repeat (3) @(posedge mclk);
    for (int c = 0; c < 13; c++) begin
      for (int k = 0; k < 60; k++) begin
        #1;
        // Second reset in mid-run
        nrst = !(c == 6 && k < 2);
        counterEnable = 4'($urandom_range(15)) | 4'h6;
        counterClear = ($urandom_range(15) == 0) ? 4'($urandom) : 4'h0;
        for (int i = 0; i < 4 && k % 20 == 0; i++) begin
          // Last pass mixes codes across counters
          c8 = (c == 12) ? codes[$urandom_range(11)] : codes[c];
          ctl[i] = {(c8 == 8'h0A) ? 8'h0F : 8'($urandom), c8};
        end
        @(posedge mclk);
      end
    end
    end_sim();
  end
endmodule
